// ==== verilog/orb_pkg.sv ====
// Purpose: Shared constants and types for the output request buffer channel
// Assumes: 16 channels, 18-bit words, 16-bit main memory addresses
// Notes:   Register offsets are byte addresses on a 32-bit classic Wishbone bus
package orb_pkg;
    // Geometry
    localparam int NCH    = 16;
    localparam int CHW    = 4;
    localparam int WORD_W = 18;
    localparam int ADDR_W = 16;
    localparam int CM_AW  = 8;
    localparam int CM_DEPTH = 256;

    // Control memory layout: terminal word at even, current word at odd location
    localparam logic [7:0] CM_TERM_BASE = 8'h20;   // 40 octal
    localparam logic [7:0] CM_HIGH_OFS  = 8'h80;   // 200 octal, channels 10-17 octal
    localparam logic [7:0] CM_ODD_BIT   = 8'h01;

    // Control word fields
    localparam int DIR_BIT = 17;   // Current word: 1 = backward buffer
    localparam int MON_BIT = 16;   // Current word: raise monitor at termination
    localparam int CDM_BIT = 17;   // Terminal word: continuous data mode

    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DUAL     = 8'h04;
    localparam logic [7:0] REG_ACTIVE   = 8'h08;
    localparam logic [7:0] REG_MONITOR  = 8'h0c;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_CM_ADDR  = 8'h14;
    localparam logic [7:0] REG_CM_DATA  = 8'h18;

    // Control and status field positions
    localparam int CTRL_LEGACY = 0;
    localparam int CTRL_CDM    = 1;
    localparam int ST_BUSY     = 0;
    localparam int ST_INIT     = 1;
    localparam int ST_LAST     = 2;
    localparam int ST_DIR      = 3;
    localparam int ST_CONT     = 4;

    // Reset values
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [15:0] MASK_RST = 16'h0000;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } orb_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } orb_wb_rsp_t;

    typedef struct packed {
        logic [NCH-1:0]    strobe;
        logic [WORD_W-1:0] data;
    } orb_word_t;

    typedef enum logic [2:0] {
        ORB_IDLE,
        ORB_SCAN_CUR,
        ORB_SCAN_TERM,
        ORB_FETCH,
        ORB_CAPTURE,
        ORB_STORE,
        ORB_ACK
    } orb_state_t;
endpackage : orb_pkg

// ==== verilog/orb_req_sync.sv ====
// Purpose: Synchronise request pins and flag their rising edges
// Assumes: Requests are levels from another clock domain
// Notes:   Edge detect reads only the second stage and its delayed copy
`timescale 1ns/1ps
module orb_req_sync #(
    parameter int N = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [N-1:0] req_pin,
    output logic      [N-1:0] req_rise
);
    // Two stages, then a third for the edge
    logic [N-1:0] stage1;
    logic [N-1:0] stage2;
    logic [N-1:0] stage3;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_ch
            always_ff @(posedge mclk) begin
                if (rst) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                    stage3[i] <= 1'b0;
                end else begin
                    stage1[i] <= req_pin[i];
                    stage2[i] <= stage1[i];
                    stage3[i] <= stage2[i];
                end
            end
            assign req_rise[i] = stage2[i] & ~stage3[i];
        end
    endgenerate
endmodule : orb_req_sync

// ==== verilog/orb_addr_step.sv ====
// Purpose: Adder network stepping the current address word by plus or minus one
// Assumes: Bits 17 and 16 of the word pass through unchanged
// Notes:   The low 16 bits wrap silently at either end
`timescale 1ns/1ps
module orb_addr_step
    import orb_pkg::*;
(
    input  wire logic [WORD_W-1:0] cur_word,
    output logic      [WORD_W-1:0] stepped
);
    logic [ADDR_W-1:0] low_next;

    // RQ20 direction from bit 17
    always_comb begin
        if (cur_word[DIR_BIT]) begin
            low_next = cur_word[ADDR_W-1:0] - 16'h0001;
        end else begin
            low_next = cur_word[ADDR_W-1:0] + 16'h0001;
        end
    end

    assign stepped = {cur_word[WORD_W-1:ADDR_W], low_next};
endmodule : orb_addr_step

// ==== verilog/orb_channel.sv ====
// Purpose: Output request buffer engine with control memory and Wishbone slave
// Assumes: Main memory answers a read one cycle after mm_rd; no CONTINUOUS_DATA_MODE reload here
// Notes:   Lowest active pending channel wins; one request in flight at a time
// Behaviour
// RQ1: Dual forward: odd channel first, even second
// RQ2: Dual backward: even channel first, odd second
// RQ3: Second word uses already stepped address
// RQ4: Compare low 16 bits on every word
// RQ5: Software sizes dual buffers in word pairs
// RQ6: Dual acknowledge on odd channel after second
// RQ7: Set initiate flag when request selected
// RQ8: Current word at 41 octal plus 2K
// RQ9: Terminal address even; force bit zero odd
// RQ10: Second control read fetches terminal word
// RQ11: Match sets last word flag, final request
// RQ12: Legacy mode: match means word not sent
// RQ13: Step by bit 17, latch direction flag
// RQ14: Fetch word at unmodified current address
// RQ15: Write stepped word back to control memory
// RQ16: Dual repeats fetch, compare, step sequence
// RQ17: Continuous request flag starts separate sequence
// RQ18: Honor request only when channel active
// RQ19: Termination clears active, maybe sets monitor
// RQ20: Bit 17 zero increments, one decrements
// RQ21: Dual requests arrive on odd channels
// RQ22: No match keeps channel active
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
module orb_channel
    import orb_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire orb_pkg::orb_wb_req_t wb_req,
    output orb_pkg::orb_wb_rsp_t     wb_rsp,
    input  wire logic [NCH-1:0]      output_request_signal,
    output logic      [NCH-1:0]      output_ack,
    output orb_pkg::orb_word_t       out_word,
    output logic      [ADDR_W-1:0]   mm_addr,
    output logic                     mm_rd,
    input  wire logic [WORD_W-1:0]   mm_data
);
    import orb_pkg::*;

    orb_state_t        state;
    logic [WORD_W-1:0] cm [CM_DEPTH];
    logic [NCH-1:0]    req_rise;
    logic [NCH-1:0]    pending;
    logic [NCH-1:0]    output_active_flag;
    logic [NCH-1:0]    output_monitor_flag;
    logic [NCH-1:0]    dual_mask;
    logic [1:0]        ctrl;
    logic [CHW-1:0]    chan;
    logic              second_word;
    logic [WORD_W-1:0] current_address_word;    // Work register
    logic [WORD_W-1:0] control_memory_data_reg; // Terminal word as read
    logic              last_word_flag;
    logic              step_dir_flag;
    logic              first_sequence_initiate_flag;
    logic              continuous_request_flag;
    logic [CM_AW-1:0]  sw_cm_addr;
    logic [WORD_W-1:0] stepped;
    logic [CM_AW-1:0]  term_addr;
    logic [CM_AW-1:0]  control_memory_address_reg;
    logic              pick_valid;
    logic [CHW-1:0]    pick_chan;
    logic              dual_mode;
    logic              addr_match;
    logic              term_now;
    logic [CHW-1:0]    word_chan;
    logic              bus_hit;
    logic              bus_wr;
    logic              eng_cm_we;

    orb_req_sync #(.N(NCH)) u_sync (
        .mclk     (mclk),
        .rst      (rst),
        .req_pin  (output_request_signal),
        .req_rise (req_rise)
    );

    // RQ13 adder network
    orb_addr_step u_step (
        .cur_word (current_address_word),
        .stepped  (stepped)
    );

    // RQ8 RQ9 even terminal location, odd current location
    assign term_addr = CM_TERM_BASE + {3'h0, chan, 1'b0} + (chan[3] ? CM_HIGH_OFS : 8'h00);
    assign control_memory_address_reg = (state == ORB_SCAN_CUR || state == ORB_STORE) ?
                                        (term_addr | CM_ODD_BIT) : term_addr;

    // RQ18 lowest-numbered active pending channel
    always_comb begin
        pick_valid = 1'b0;
        pick_chan  = '0;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (pending[i] && output_active_flag[i]) begin
                pick_valid = 1'b1;
                pick_chan  = CHW'(i);
            end
        end
    end

    // RQ21 dual mode only meaningful on an odd channel
    assign dual_mode  = dual_mask[chan] & chan[0];
    // RQ4 low 16 bits compared on every word
    assign addr_match = current_address_word[ADDR_W-1:0] == control_memory_data_reg[ADDR_W-1:0];
    // RQ12 legacy match ends before send; otherwise after the sent word
    assign term_now   = last_word_flag &&
                        ((state == ORB_CAPTURE && ctrl[CTRL_LEGACY]) ||
                         (state == ORB_STORE && !ctrl[CTRL_LEGACY]));
    // RQ1 RQ2 receiving channel per word and direction
    assign word_chan  = !dual_mode ? chan :
                        ((second_word ^ step_dir_flag) ? {chan[CHW-1:1], 1'b0} : chan);
    assign bus_hit    = wb_req.cyc & wb_req.stb;
    assign eng_cm_we  = state == ORB_STORE;
    // Software control-memory write waits out an engine write-back
    assign bus_wr     = bus_hit & wb_req.we & wb_rsp.ack;

    // Sequencer
    always_ff @(posedge mclk) begin
        if (rst) begin
            state       <= ORB_IDLE;
            chan        <= '0;
            second_word <= 1'b0;
        end else begin
            unique case (state)
                ORB_IDLE: begin
                    if (pick_valid) begin
                        chan        <= pick_chan;
                        second_word <= 1'b0;
                        state       <= ORB_SCAN_CUR;
                    end
                end
                ORB_SCAN_CUR:  state <= ORB_SCAN_TERM;
                ORB_SCAN_TERM: state <= ORB_FETCH;
                ORB_FETCH:     state <= ORB_CAPTURE;
                ORB_CAPTURE: begin
                    // RQ12 legacy mode skips the matched word
                    if (term_now) begin
                        state <= ORB_ACK;
                    end else begin
                        state <= ORB_STORE;
                    end
                end
                ORB_STORE: begin
                    // RQ16 second word repeats from the control read
                    if (dual_mode && !second_word && !last_word_flag) begin
                        second_word <= 1'b1;
                        state       <= ORB_SCAN_CUR;
                    end else begin
                        state <= ORB_ACK;
                    end
                end
                ORB_ACK:       state <= ORB_IDLE;
            endcase
        end
    end

    // RQ10 RQ11 RQ13 work registers, compare result, direction
    always_ff @(posedge mclk) begin
        if (rst) begin
            current_address_word    <= '0;
            control_memory_data_reg <= '0;
            last_word_flag          <= 1'b0;
            step_dir_flag           <= 1'b0;
        end else if (state == ORB_SCAN_CUR) begin
            current_address_word <= cm[control_memory_address_reg];
        end else if (state == ORB_SCAN_TERM) begin
            control_memory_data_reg <= cm[control_memory_address_reg];
            step_dir_flag           <= current_address_word[DIR_BIT];
        end else if (state == ORB_FETCH) begin
            last_word_flag <= addr_match;
        end
    end

    // RQ15 RQ3 stepped word back, software port otherwise
    always_ff @(posedge mclk) begin
        if (eng_cm_we) begin
            cm[control_memory_address_reg] <= stepped;
        end else if (bus_wr && wb_req.adr == REG_CM_DATA) begin
            cm[sw_cm_addr] <= wb_req.dat[WORD_W-1:0];
        end
    end

    // RQ14 main memory read at the unmodified address
    always_ff @(posedge mclk) begin
        if (rst) begin
            mm_addr <= '0;
            mm_rd   <= 1'b0;
        end else begin
            mm_rd <= state == ORB_FETCH;
            if (state == ORB_FETCH) begin
                mm_addr <= current_address_word[ADDR_W-1:0];
            end
        end
    end

    // RQ1 RQ2 word strobe on the receiving channel
    always_ff @(posedge mclk) begin
        if (rst) begin
            out_word <= '0;
        end else begin
            out_word.strobe <= '0;
            if (state == ORB_STORE) begin
                out_word.data              <= mm_data;
                out_word.strobe[word_chan] <= 1'b1;
            end
        end
    end

    // RQ6 acknowledge once, on the requesting channel
    always_ff @(posedge mclk) begin
        if (rst) begin
            output_ack <= '0;
        end else begin
            output_ack <= '0;
            if (state == ORB_ACK) begin
                output_ack[chan] <= 1'b1;
            end
        end
    end

    // RQ7 initiate flag marks a selected request in flight
    always_ff @(posedge mclk) begin
        if (rst) begin
            first_sequence_initiate_flag <= 1'b0;
        end else if (state == ORB_IDLE && pick_valid) begin
            first_sequence_initiate_flag <= 1'b1;
        end else if (state == ORB_ACK) begin
            first_sequence_initiate_flag <= 1'b0;
        end
    end

    // Pending requests; new edge wins over the acknowledge clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            pending <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (req_rise[i] && output_active_flag[i]) begin
                    pending[i] <= 1'b1;
                end else if ((state == ORB_ACK && chan == CHW'(i)) || !output_active_flag[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    // RQ19 RQ22 only termination drops the active flag; software set wins
    always_ff @(posedge mclk) begin
        if (rst) begin
            output_active_flag <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (bus_wr && wb_req.adr == REG_ACTIVE && wb_req.dat[i]) begin
                    output_active_flag[i] <= 1'b1;
                end else if (term_now && chan == CHW'(i)) begin
                    output_active_flag[i] <= 1'b0;
                end
            end
        end
    end

    // RQ19 monitor on termination when bit 16 set; set beats clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            output_monitor_flag <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (term_now && chan == CHW'(i) && control_memory_data_reg[ADDR_W-1:0] ==
                    current_address_word[ADDR_W-1:0] && current_address_word[MON_BIT]) begin
                    output_monitor_flag[i] <= 1'b1;
                end else if (bus_wr && wb_req.adr == REG_MONITOR && wb_req.dat[i]) begin
                    output_monitor_flag[i] <= 1'b0;
                end
            end
        end
    end

    // RQ17 continuous request flag set at termination in CDM, cleared by software; no reload sequence here
    always_ff @(posedge mclk) begin
        if (rst) begin
            continuous_request_flag <= 1'b0;
        end else if (term_now && control_memory_data_reg[CDM_BIT] && ctrl[CTRL_CDM]) begin
            continuous_request_flag <= 1'b1;
        end else if (bus_wr && wb_req.adr == REG_STATUS && wb_req.dat[ST_CONT]) begin
            continuous_request_flag <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl       <= CTRL_RST;
            dual_mask  <= MASK_RST;
            sw_cm_addr <= '0;
        end else if (bus_wr) begin
            if (wb_req.adr == REG_CTRL) begin
                ctrl <= wb_req.dat[1:0];
            end
            if (wb_req.adr == REG_DUAL) begin
                dual_mask <= wb_req.dat[NCH-1:0];
            end
            if (wb_req.adr == REG_CM_ADDR) begin
                sw_cm_addr <= wb_req.dat[CM_AW-1:0];
            end
        end
    end

    // Bus answer one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_rsp <= '0;
        end else begin
            // A write seen in CAPTURE would be acked in STORE and lose the array port
            wb_rsp.ack <= bus_hit & ~wb_rsp.ack & ~((state == ORB_CAPTURE) & wb_req.we);
            unique case (wb_req.adr)
                REG_CTRL:    wb_rsp.dat <= {30'h0, ctrl};
                REG_DUAL:    wb_rsp.dat <= {16'h0, dual_mask};
                REG_ACTIVE:  wb_rsp.dat <= {16'h0, output_active_flag};
                REG_MONITOR: wb_rsp.dat <= {16'h0, output_monitor_flag};
                REG_STATUS:  wb_rsp.dat <= {27'h0, continuous_request_flag, step_dir_flag,
                                            last_word_flag, first_sequence_initiate_flag,
                                            state != ORB_IDLE};
                REG_CM_ADDR: wb_rsp.dat <= {24'h0, sw_cm_addr};
                REG_CM_DATA: wb_rsp.dat <= {14'h0, cm[sw_cm_addr]};
                default:     wb_rsp.dat <= 32'h0;
            endcase
        end
    end

    // RQ14 memory address is the unstepped word
    property p_fetch_addr;
        @(posedge mclk) disable iff (rst)
        state == ORB_FETCH |=> mm_rd && mm_addr == $past(current_address_word[ADDR_W-1:0]);
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not unstepped"); // RQ14

    // RQ15 write-back stores the stepped word
    property p_store_step;
        @(posedge mclk) disable iff (rst)
        state == ORB_STORE |=> cm[$past(control_memory_address_reg)] == $past(stepped);
    endproperty
    a_store_step: assert property (p_store_step) else $error("stepped word not stored"); // RQ15

    // RQ20 direction of the step
    property p_step_dir;
        @(posedge mclk) disable iff (rst)
        state == ORB_STORE |-> stepped[ADDR_W-1:0] == (current_address_word[DIR_BIT] ?
            current_address_word[ADDR_W-1:0] - 16'h0001 : current_address_word[ADDR_W-1:0] + 16'h0001);
    endproperty
    a_step_dir: assert property (p_step_dir) else $error("wrong step direction"); // RQ20

    // RQ6 acknowledge follows the last word by one cycle, on the request channel
    property p_ack_after;
        @(posedge mclk) disable iff (rst)
        state == ORB_STORE && !(dual_mode && !second_word && !last_word_flag)
            |=> ##1 output_ack == (16'h0001 << $past(chan, 2));
    endproperty
    a_ack_after: assert property (p_ack_after) else $error("acknowledge missing or misplaced"); // RQ6

    // RQ1 RQ2 first dual word lands on the documented channel
    property p_dual_order;
        @(posedge mclk) disable iff (rst)
        state == ORB_STORE && dual_mode && !second_word
            |=> out_word.strobe[$past(chan) ^ 4'($past(step_dir_flag))];
    endproperty
    a_dual_order: assert property (p_dual_order) else $error("dual word order wrong"); // RQ1

    // RQ12 legacy match sends nothing
    property p_legacy_skip;
        @(posedge mclk) disable iff (rst)
        state == ORB_CAPTURE && ctrl[CTRL_LEGACY] && last_word_flag |=> (out_word.strobe == '0) [*2];
    endproperty
    a_legacy_skip: assert property (p_legacy_skip) else $error("legacy matched word was sent"); // RQ12

    // RQ19 termination drops the active flag
    property p_term_clear;
        @(posedge mclk) disable iff (rst)
        term_now && !(bus_wr && wb_req.adr == REG_ACTIVE) |=> !output_active_flag[$past(chan)];
    endproperty
    a_term_clear: assert property (p_term_clear) else $error("active flag kept at termination"); // RQ19

    // RQ22 no match leaves the channel active
    property p_keep_active;
        @(posedge mclk) disable iff (rst)
        state == ORB_STORE && !last_word_flag && output_active_flag[chan] |=> output_active_flag[$past(chan)];
    endproperty
    a_keep_active: assert property (p_keep_active) else $error("active flag lost without match"); // RQ22

    // RQ18 inactive channels are never selected
    property p_only_active;
        @(posedge mclk) disable iff (rst)
        state == ORB_IDLE && pick_valid |=> output_active_flag[chan] || $past(term_now);
    endproperty
    a_only_active: assert property (p_only_active) else $error("inactive channel served"); // RQ18

    // RQ7 initiate flag stands while a request is served
    property p_init_flag;
        @(posedge mclk) disable iff (rst)
        state != ORB_IDLE |-> first_sequence_initiate_flag;
    endproperty
    a_init_flag: assert property (p_init_flag) else $error("initiate flag low during service"); // RQ7
endmodule : orb_channel

// ==== bench/orb_mem_model.sv ====
// Purpose: Main memory model answering engine reads
// Assumes: Data due one cycle after the read pulse
// Notes:   Idle bus toggles so stale data never matches
`timescale 1ns/1ps
module orb_mem_model
    import orb_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic [ADDR_W-1:0] mm_addr,
    input  wire logic              mm_rd,
    output logic      [WORD_W-1:0] mm_data
);
    logic              rd_d = 1'b0;
    logic [ADDR_W-1:0] a_d  = '0;
    logic [WORD_W-1:0] last = '0;
    // Capture the address, answer next cycle
    always_ff @(posedge mclk) begin
        rd_d <= mm_rd;
        last <= mm_data;
        if (mm_rd) begin
            a_d <= mm_addr;
        end
    end
    // Word content mixes its own address
    assign mm_data = rd_d ? {2'h1, a_d ^ 16'h3c3c} : ~last;
endmodule : orb_mem_model

// ==== bench/orb_channel_test.sv ====
// Purpose: Self-checking bench for the output request engine
// Assumes: Control words loaded over Wishbone before each request
// Notes:   Rows hold single, dual, legacy and continuous-mode buffers; odd cases follow the loop
`timescale 1ns/1ps
module orb_channel_test;
    import orb_pkg::*;
    typedef struct packed {
        logic [3:0]  ch;
        logic        dual;
        logic [1:0]  ctrl;
        logic [17:0] cur;
        logic [17:0] term;
        logic [1:0]  nstr;
        logic        act;
        logic [17:0] nxt;
    } orb_row_t;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    orb_wb_req_t wbq  = '0;
    orb_wb_rsp_t wbs;
    logic [15:0] req  = 16'h0;
    logic [15:0] ack;
    orb_word_t   ow;
    logic [15:0] ma;
    logic        mr;
    logic [17:0] md;
    logic [15:0] sv[$];
    logic [17:0] dv[$];
    logic [15:0] av;
    logic [31:0] q;
    int          an;
    int          fails     = 0;
    int          tests_run = 0;
    orb_row_t rows[7] = '{
        '{4'h3, 1'h0, 2'h0, 18'h05000, 18'h05003, 2'h1, 1'h1, 18'h05001},
        '{4'h3, 1'h1, 2'h0, 18'h05000, 18'h05003, 2'h2, 1'h1, 18'h05002},
        '{4'h3, 1'h1, 2'h0, 18'h25003, 18'h05000, 2'h2, 1'h1, 18'h25001},
        '{4'h3, 1'h1, 2'h2, 18'h05002, 18'h25003, 2'h2, 1'h0, 18'h05004},
        '{4'h3, 1'h1, 2'h0, 18'h15003, 18'h05003, 2'h1, 1'h0, 18'h15004},
        '{4'ha, 1'h0, 2'h0, 18'h35003, 18'h05003, 2'h1, 1'h0, 18'h35002},
        '{4'hc, 1'h0, 2'h1, 18'h05007, 18'h05007, 2'h0, 1'h0, 18'h05007}};
    // Clock
    always #20 mclk = ~mclk;
    orb_channel u_dut (.mclk(mclk), .rst(rst), .wb_req(wbq), .wb_rsp(wbs),
        .output_request_signal(req), .output_ack(ack), .out_word(ow),
        .mm_addr(ma), .mm_rd(mr), .mm_data(md));
    orb_mem_model u_mem (.mclk(mclk), .mm_addr(ma), .mm_rd(mr), .mm_data(md));
    // Log strobes; note word count at acknowledge
    always @(posedge mclk) begin
        if (ow.strobe !== 16'h0) begin
            sv.push_back(ow.strobe);
            dv.push_back(ow.data);
        end
        if (ack !== 16'h0) begin
            av = ack;
            an = sv.size();
        end
    end
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // One classic cycle; waits for ack under a bound
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        wbq <= '{1'b1, 1'b1, we, 4'hf, a, d};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (wbs.ack !== 1'b1 && n < 40);
        if (n >= 40) fails++;
        q = wbs.dat;
        wbq.cyc <= 1'b0;
        wbq.stb <= 1'b0;
    endtask : wb
    task automatic pulse(input logic [15:0] m);
        sv.delete();
        dv.delete();
        av = 16'h0;
        @(posedge mclk);
        req <= m;
        repeat (4) @(posedge mclk);
        req <= 16'h0;
        for (int n = 0; n < 60 && av === 16'h0; n++) @(posedge mclk);
    endtask : pulse
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        orb_row_t    r;
        logic [7:0]  b;
        logic [15:0] m;
        logic [15:0] a1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        chk("strobe rst", 32'(ow.strobe), 32'h0);
        wb(1'b0, REG_ACTIVE, 32'h0);
        chk("active rst", q, 32'(MASK_RST));
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", q, 32'h0);
        foreach (rows[i]) begin
            r = rows[i];
            b = 8'h20 + {3'h0, r.ch, 1'b0} + (r.ch[3] ? 8'h80 : 8'h00);
            m = 16'h1 << r.ch;
            wb(1'b1, REG_CTRL, {30'h0, r.ctrl});
            wb(1'b1, REG_DUAL, r.dual ? {16'h0, m} : 32'h0);
            wb(1'b1, REG_CM_ADDR, {24'h0, b});
            wb(1'b1, REG_CM_DATA, {14'h0, r.term});
            wb(1'b1, REG_CM_ADDR, {24'h0, b | 8'h01});
            wb(1'b1, REG_CM_DATA, {14'h0, r.cur});
            wb(1'b1, REG_ACTIVE, {16'h0, m});
            pulse(m);
            chk("ack chan", 32'(av), 32'(m));
            chk("ack after", an, r.nstr);
            chk("words", sv.size(), r.nstr);
            for (int k = 0; k < r.nstr; k++) begin
                a1 = r.cur[15:0] + ((k == 0) ? 16'h0 : (r.cur[17] ? 16'hffff : 16'h1));
                chk("chan", 32'(sv[k]), 32'(((k == 0) == (r.dual & r.cur[17])) ? m >> 1 : m));
                chk("word", 32'(dv[k]), {14'h0, 2'h1, a1 ^ 16'h3c3c});
            end
            wb(1'b0, REG_CM_DATA, 32'h0);
            chk("cur word", q, {14'h0, r.nxt});
            wb(1'b0, REG_ACTIVE, 32'h0);
            chk("active", 32'(q[r.ch]), 32'(r.act));
            wb(1'b0, REG_MONITOR, 32'h0);
            chk("monitor", 32'(q[r.ch]), 32'(!r.act & r.cur[16]));
            wb(1'b0, REG_STATUS, 32'h0);
            chk("cont", 32'(q[ST_CONT]), 32'(!r.act & r.term[17] & r.ctrl[1]));
            chk("status", 32'(q[3:0]), 32'({r.cur[17], !r.act, 2'b00}));
            wb(1'b1, REG_MONITOR, {16'h0, m});
            wb(1'b1, REG_STATUS, 32'h10);
        end
        // Terminated channel must ignore requests
        pulse(16'h1000);
        chk("dropped", sv.size(), 0);
        chk("no ack", 32'(av), 32'h0);
        // Mid-run reset drops flags and configuration
        wb(1'b1, REG_ACTIVE, 32'h0000ffff);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wb(1'b0, REG_ACTIVE, 32'h0);
        chk("active rst2", q, 32'(MASK_RST));
        wb(1'b0, REG_CTRL, 32'h0);
        chk("ctrl rst", q, 32'(CTRL_RST));
        test_done();
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        test_done();
    end
endmodule : orb_channel_test
